// >>> verilog/seeb_pkg.sv
`default_nettype none
package seeb_pkg;
    // System clock and serial clock rates
    localparam int SYS_HZ = 10_000_000;
    localparam int SCL_HZ = 100_000;
    localparam int SCL_QTR_CYCLES = SYS_HZ / (4 * SCL_HZ);
    localparam int QTR_W = 5;
    // Self-timed programming cycle
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * (SYS_HZ / 1_000_000);
    localparam int PROG_TIMER_W = 17;
    // Array and page geometry; 4096 selects the smaller array
    localparam int MEM_BYTES = 8192;
    localparam int ADDR_W = $clog2(MEM_BYTES);
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam logic [5:0] PAGE_BYTES_6 = 6'h20;
    // Bit positions inside a nine-clock byte slot
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Device type code; arbitrary value
    localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
    // Host command limits
    localparam logic [5:0] MAX_DATA_BYTES = 6'h20;
    localparam logic [5:0] HDR_BYTES = 6'h02;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    typedef enum logic [5:0] {
        SEEB_DS_IDLE = 6'h01,
        SEEB_DS_DEVADDR = 6'h02,
        SEEB_DS_ADDR_HI = 6'h04,
        SEEB_DS_ADDR_LO = 6'h08,
        SEEB_DS_DATA = 6'h10,
        SEEB_DS_IGNORE = 6'h20
    } seeb_dev_state_t;

    typedef enum logic [3:0] {
        SEEB_HS_IDLE = 4'h1,
        SEEB_HS_START = 4'h2,
        SEEB_HS_BITS = 4'h4,
        SEEB_HS_STOP = 4'h8
    } seeb_host_state_t;
endpackage
`default_nettype wire

// >>> verilog/seeb_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seeb_link_if;
    logic scl;
    logic sda_host_out;
    logic sda_host_oe;
    logic sda_dev_out;
    logic sda_dev_oe;
    wire logic sda;

    // Open-drain wire with pull-up: low whenever any enabled driver pulls low
    assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

    modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
    modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
endinterface
`default_nettype wire

// >>> verilog/seeb_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: Master alone drives clock and framing.
// RULE2: Master starts only on idle bus.
// RULE3: Data steady while clock high.
// RULE4: Data fall with clock high is START.
// RULE5: Silent until START is seen.
// RULE6: Data rise with clock high is STOP.
// RULE7: Receiver pulls data low on ninth clock.
// RULE8: Upper four address bits hold type code.
// RULE9: Next three bits match strap pins.
// RULE10: Floating strap pins read as zero.
// RULE11: Lowest address bit: one read, zero write.
// RULE12: Acknowledge address only on full match.
// RULE13: Byte write: address, two pointer bytes, data.
// RULE14: Programming from STOP ignores the bus.
// RULE15: Programming self-times for about 5 ms.
// RULE16: Up to 31 more bytes fill page.
// RULE17: Acknowledge data, bump five low bits.
// RULE18: Over 32 bytes wrap inside page.
// RULE19: STOP commits whole page in one cycle.
// RULE20: Write protect high makes array read-only.
// RULE21: Array size sets pointer width.
// RULE22: No address acknowledge while programming.
// RULE23: Pointer bits above array are ignored.
// RULE24: Protected writes acknowledged but never programmed.
module seeb_dev #(
    parameter int PROG_CYCLES = seeb_pkg::PROG_CYCLES
) (
    input wire logic sys_clk_in,                // System clock
    input wire logic reset_in,                  // Reset, high; synchronous in system clock domain, asynchronous in link domain
    seeb_link_if.dev link,                      // Two-wire link
    input wire logic strap_select_bit0_in,      // Strap pin, bit 0
    input wire logic strap_select_bit1_in,      // Strap pin, bit 1
    input wire logic strap_select_bit2_in,      // Strap pin, bit 2
    input wire logic write_protect_in,          // High blocks programming
    output logic prog_valid_out,                // Byte commit strobe
    output logic [seeb_pkg::ADDR_W-1:0] prog_addr_out, // Commit address
    output logic [7:0] prog_data_out,           // Commit data
    output logic busy_out                       // Programming cycle active
);
    // ---------------- Link clock domain ----------------
    seeb_pkg::seeb_dev_state_t state_q;
    logic sda_rise_q;
    logic stop_q;
    logic [2:0] strap_m_q;
    logic [2:0] strap_s_q;
    logic busy_m_q;
    logic busy_s_q;
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic ack_oe_q;
    logic got_data_q;
    logic wr_tog_q;
    logic [seeb_pkg::ADDR_W-1:0] word_ptr_q;
    logic [seeb_pkg::PAGE_BYTES-1:0][7:0] page_buf_q;
    logic [seeb_pkg::PAGE_BYTES-1:0] page_mask_q;
    logic start_det;
    logic last_bit;
    logic [7:0] byte_in;
    logic addr_match;
    logic frame_open;
    logic buf_wr;

    // Open drain: only ever pulls low
    assign link.sda_dev_out = 1'b0;
    assign link.sda_dev_oe = ack_oe_q;

    // Sample data on the rising edge; link data needs no synchroniser here.
    // A STOP leaves a low sample behind, so it presets the sample to let the
    // next START be seen; the preset ends while the clock still stands high.
    always_ff @(posedge link.scl or posedge reset_in or posedge stop_q) begin
        if (reset_in || stop_q) begin
            sda_rise_q <= 1'b1;
        end else begin
            sda_rise_q <= link.sda;
        end
    end

    // Straps and busy come from outside this domain
    always_ff @(posedge link.scl or posedge reset_in) begin
        if (reset_in) begin
            strap_m_q <= 3'h0;
            strap_s_q <= 3'h0;
            busy_m_q <= 1'b0;
            busy_s_q <= 1'b0;
        end else begin
            strap_m_q <= {strap_select_bit2_in, strap_select_bit1_in, strap_select_bit0_in};
            strap_s_q <= strap_m_q;
            busy_m_q <= busy_out;
            busy_s_q <= busy_m_q;
        end
    end

    // RULE4: high-to-low while high
    assign start_det = sda_rise_q && !link.sda;
    assign byte_in = {shift_q, sda_rise_q};
    assign last_bit = !start_det && (bit_cnt_q == seeb_pkg::BIT_LAST);
    // RULE8: type code compare
    // RULE9: strap compare
    // RULE10: floating straps are pulled low outside
    assign addr_match = (byte_in[7:4] == seeb_pkg::DEV_TYPE_CODE)
        && (byte_in[3:1] == strap_s_q);
    // RULE11: direction bit zero writes
    // RULE22: refuse while programming
    assign frame_open = last_bit && (state_q == seeb_pkg::SEEB_DS_DEVADDR)
        && addr_match && !busy_s_q && !byte_in[0];
    assign buf_wr = last_bit && (state_q == seeb_pkg::SEEB_DS_DATA);

    // Byte framing, state and acknowledge, all on the falling edge
    always_ff @(negedge link.scl or posedge reset_in) begin
        if (reset_in) begin
            state_q <= seeb_pkg::SEEB_DS_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 7'h00;
        // RULE5: leave idle only on START
        end else if (start_det) begin
            state_q <= seeb_pkg::SEEB_DS_DEVADDR;
            bit_cnt_q <= 4'h0;
        end else if (state_q != seeb_pkg::SEEB_DS_IDLE) begin
            shift_q <= byte_in[6:0];
            if (bit_cnt_q == seeb_pkg::BIT_ACK) begin
                bit_cnt_q <= 4'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (last_bit) begin
                case (state_q)
                    seeb_pkg::SEEB_DS_DEVADDR: begin
                        // RULE14: ignore own address while busy
                        state_q <= frame_open ? seeb_pkg::SEEB_DS_ADDR_HI
                            : seeb_pkg::SEEB_DS_IGNORE;
                    end
                    seeb_pkg::SEEB_DS_ADDR_HI: state_q <= seeb_pkg::SEEB_DS_ADDR_LO;
                    seeb_pkg::SEEB_DS_ADDR_LO: state_q <= seeb_pkg::SEEB_DS_DATA;
                    seeb_pkg::SEEB_DS_DATA: state_q <= seeb_pkg::SEEB_DS_DATA;
                    seeb_pkg::SEEB_DS_IGNORE: state_q <= seeb_pkg::SEEB_DS_IGNORE;
                    default: state_q <= seeb_pkg::SEEB_DS_IDLE;
                endcase
            end
        end
    end

    // RULE3: changes at clock fall
    // Pull low for the ninth clock of an accepted byte
    always_ff @(negedge link.scl or posedge reset_in) begin
        if (reset_in) begin
            ack_oe_q <= 1'b0;
        end else if (!last_bit) begin
            ack_oe_q <= 1'b0;
        end else begin
            case (state_q)
                // RULE12: address acknowledged only on match
                // RULE7: ninth clock acknowledge
                seeb_pkg::SEEB_DS_DEVADDR: begin
                    ack_oe_q <= addr_match && !busy_s_q;
                end
                // RULE13: pointer bytes acknowledged
                seeb_pkg::SEEB_DS_ADDR_HI: ack_oe_q <= 1'b1;
                seeb_pkg::SEEB_DS_ADDR_LO: ack_oe_q <= 1'b1;
                // RULE24: data acknowledged even when protected
                seeb_pkg::SEEB_DS_DATA: ack_oe_q <= 1'b1;
                default: ack_oe_q <= 1'b0;
            endcase
        end
    end

    // Word pointer
    always_ff @(negedge link.scl or posedge reset_in) begin
        if (reset_in) begin
            word_ptr_q <= '0;
        end else if (last_bit && (state_q == seeb_pkg::SEEB_DS_ADDR_HI)) begin
            // RULE21: pointer as wide as the array
            // RULE23: upper pointer bits dropped
            word_ptr_q[seeb_pkg::ADDR_W-1:8] <= byte_in[seeb_pkg::ADDR_W-9:0];
        end else if (last_bit && (state_q == seeb_pkg::SEEB_DS_ADDR_LO)) begin
            word_ptr_q[7:0] <= byte_in;
        end else if (buf_wr) begin
            // RULE17: only five low bits advance
            // RULE18: wrap inside the page
            word_ptr_q[seeb_pkg::PAGE_W-1:0] <= word_ptr_q[seeb_pkg::PAGE_W-1:0]
                + seeb_pkg::PAGE_W'(1);
        end
    end

    // Toggle once per write frame that carried data
    always_ff @(negedge link.scl or posedge reset_in) begin
        if (reset_in) begin
            got_data_q <= 1'b0;
            wr_tog_q <= 1'b0;
        end else if (frame_open) begin
            got_data_q <= 1'b0;
        end else if (buf_wr && !got_data_q) begin
            got_data_q <= 1'b1;
            wr_tog_q <= !wr_tog_q;
        end
    end

    // RULE16: page buffer, one entry per byte
    for (genvar gi = 0; gi < seeb_pkg::PAGE_BYTES; gi++) begin : g_page
        always_ff @(negedge link.scl or posedge reset_in) begin
            if (reset_in) begin
                page_buf_q[gi] <= 8'h00;
                page_mask_q[gi] <= 1'b0;
            end else if (frame_open) begin
                page_mask_q[gi] <= 1'b0;
            // RULE18: later bytes replace earlier
            end else if (buf_wr
                && (word_ptr_q[seeb_pkg::PAGE_W-1:0] == seeb_pkg::PAGE_W'(gi))) begin
                page_buf_q[gi] <= byte_in;
                page_mask_q[gi] <= 1'b1;
            end
        end
    end

    // ---------------- System clock domain ----------------
    logic scl_m_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_p_q;
    logic wp_m_q;
    logic wp_s_q;
    logic tog_m_q;
    logic tog_s_q;
    logic seen_q;
    logic [seeb_pkg::PROG_TIMER_W-1:0] timer_q;
    logic [5:0] idx_q;
    logic stop_det;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            {wp_m_q, wp_s_q} <= 2'h0;
            {tog_m_q, tog_s_q} <= 2'h0;
            stop_q <= 1'b0;
        end else begin
            scl_m_q <= link.scl;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= link.sda;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            wp_m_q <= write_protect_in;
            wp_s_q <= wp_m_q;
            tog_m_q <= wr_tog_q;
            tog_s_q <= tog_m_q;
            stop_q <= stop_det;
        end
    end

    // RULE6: low-to-high while high
    assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            busy_out <= 1'b0;
            seen_q <= 1'b0;
            timer_q <= '0;
            idx_q <= 6'h0;
        end else if (!busy_out) begin
            if (stop_det && (tog_s_q != seen_q)) begin
                seen_q <= tog_s_q;
                // RULE20: protected array stays unchanged
                // RULE24: no cycle when protected
                busy_out <= !wp_s_q;
                timer_q <= '0;
                idx_q <= 6'h0;
            end
        end else begin
            // RULE15: self-timed, clears itself
            timer_q <= timer_q + seeb_pkg::PROG_TIMER_W'(1);
            if (timer_q == seeb_pkg::PROG_TIMER_W'(PROG_CYCLES - 1)) begin
                busy_out <= 1'b0;
            end
            if (idx_q != seeb_pkg::PAGE_BYTES_6) begin
                idx_q <= idx_q + 6'h1;
            end
        end
    end

    // RULE19: buffered bytes leave in one cycle
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            prog_valid_out <= 1'b0;
            prog_addr_out <= '0;
            prog_data_out <= 8'h00;
        end else begin
            prog_valid_out <= busy_out && (idx_q != seeb_pkg::PAGE_BYTES_6)
                && page_mask_q[idx_q[seeb_pkg::PAGE_W-1:0]];
            prog_addr_out <= {word_ptr_q[seeb_pkg::ADDR_W-1:seeb_pkg::PAGE_W],
                idx_q[seeb_pkg::PAGE_W-1:0]};
            prog_data_out <= page_buf_q[idx_q[seeb_pkg::PAGE_W-1:0]];
        end
    end
endmodule
`default_nettype wire

// >>> verilog/seeb_host.sv
`timescale 1ns/1ps
`default_nettype none
module seeb_host (
    input wire logic sys_clk_in,        // System clock
    input wire logic reset_in,          // Synchronous reset, high
    seeb_link_if.host link,             // Two-wire link
    input wire logic cmd_valid_in,      // Command request
    output logic cmd_ready_out,         // Idle, command accepted
    input wire logic [2:0] cmd_strap_in, // Target strap value
    input wire logic [15:0] cmd_addr_in, // Word address
    input wire logic [5:0] cmd_len_in,  // Data bytes, 0 polls
    input wire logic [7:0] data_in,     // Next data byte
    output logic data_take_out,         // Data byte taken
    output logic done_out,              // Operation finished
    output logic nack_out               // A byte went unacknowledged
);
    seeb_pkg::seeb_host_state_t state_q;
    logic [seeb_pkg::QTR_W-1:0] qcnt_q;
    logic [1:0] phase_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [5:0] byte_q;
    logic [5:0] last_q;
    logic [15:0] addr_q;
    logic sda_m_q;
    logic sda_s_q;
    logic tick;
    logic acked;

    assign link.sda_host_out = 1'b0;
    assign tick = (qcnt_q == seeb_pkg::QTR_W'(seeb_pkg::SCL_QTR_CYCLES - 1));
    assign acked = !sda_s_q;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            sda_m_q <= link.sda;
            sda_s_q <= sda_m_q;
        end
    end

    // Quarter-period divider; the serial clock is derived from it
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || tick || (cmd_valid_in && cmd_ready_out)) begin
            qcnt_q <= '0;
        end else begin
            qcnt_q <= qcnt_q + seeb_pkg::QTR_W'(1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        data_take_out <= 1'b0;
        done_out <= 1'b0;
        if (reset_in) begin
            state_q <= seeb_pkg::SEEB_HS_IDLE;
            cmd_ready_out <= 1'b1;
            nack_out <= 1'b0;
            link.scl <= 1'b1;
            link.sda_host_oe <= 1'b0;
            phase_q <= 2'h0;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            byte_q <= 6'h0;
            last_q <= 6'h0;
            addr_q <= 16'h0000;
        end else begin
            case (state_q)
                seeb_pkg::SEEB_HS_IDLE: begin
                    // RULE2: start only from idle bus
                    if (cmd_valid_in) begin
                        cmd_ready_out <= 1'b0;
                        nack_out <= 1'b0;
                        state_q <= seeb_pkg::SEEB_HS_START;
                        phase_q <= 2'h0;
                        shift_q <= {seeb_pkg::DEV_TYPE_CODE, cmd_strap_in, 1'b0};
                        addr_q <= cmd_addr_in;
                        byte_q <= 6'h0;
                        // RULE16: at most 32 data bytes
                        // RULE13: two pointer bytes before data
                        if (cmd_len_in == 6'h0) begin
                            last_q <= 6'h0;
                        end else if (cmd_len_in > seeb_pkg::MAX_DATA_BYTES) begin
                            last_q <= seeb_pkg::MAX_DATA_BYTES + seeb_pkg::HDR_BYTES;
                        end else begin
                            last_q <= cmd_len_in + seeb_pkg::HDR_BYTES;
                        end
                    end
                end
                seeb_pkg::SEEB_HS_START: begin
                    if (tick) begin
                        phase_q <= phase_q + 2'h1;
                        // RULE1: master makes START and clock
                        if (phase_q == 2'h1) begin
                            link.sda_host_oe <= 1'b1;
                        end
                        if (phase_q == 2'h2) begin
                            link.scl <= 1'b0;
                        end
                        if (phase_q == seeb_pkg::PHASE_LAST) begin
                            state_q <= seeb_pkg::SEEB_HS_BITS;
                            bit_q <= 4'h0;
                        end
                    end
                end
                seeb_pkg::SEEB_HS_BITS: begin
                    if (tick) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            // RULE3: data changes only while low
                            2'h0: begin
                                link.sda_host_oe <= (bit_q != seeb_pkg::BIT_ACK) && !shift_q[7];
                            end
                            2'h1: link.scl <= 1'b1;
                            2'h2: link.scl <= 1'b1;
                            default: begin
                                link.scl <= 1'b0;
                                // RULE7: ninth clock carries acknowledge
                                if (bit_q != seeb_pkg::BIT_ACK) begin
                                    shift_q <= {shift_q[6:0], 1'b0};
                                    bit_q <= bit_q + 4'h1;
                                end else if (!acked || (byte_q == last_q)) begin
                                    nack_out <= !acked;
                                    state_q <= seeb_pkg::SEEB_HS_STOP;
                                end else begin
                                    bit_q <= 4'h0;
                                    byte_q <= byte_q + 6'h1;
                                    if (byte_q == 6'h0) begin
                                        shift_q <= addr_q[15:8];
                                    end else if (byte_q == 6'h1) begin
                                        shift_q <= addr_q[7:0];
                                    end else begin
                                        shift_q <= data_in;
                                        data_take_out <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
                seeb_pkg::SEEB_HS_STOP: begin
                    if (tick) begin
                        phase_q <= phase_q + 2'h1;
                        // RULE6: every operation ends with STOP
                        case (phase_q)
                            2'h0: link.sda_host_oe <= 1'b1;
                            2'h1: link.scl <= 1'b1;
                            2'h2: link.sda_host_oe <= 1'b0;
                            default: begin
                                done_out <= 1'b1;
                                cmd_ready_out <= 1'b1;
                                state_q <= seeb_pkg::SEEB_HS_IDLE;
                            end
                        endcase
                    end
                end
                default: state_q <= seeb_pkg::SEEB_HS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/seeb_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module seeb_link_sva #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic sys_clk_in,    // System clock
    input wire logic reset_in,      // Reset, high
    input wire logic scl,           // Serial clock
    input wire logic sda,           // Resolved data line
    input wire logic sda_dev_oe,    // Device pull-down
    input wire logic busy_out,      // Programming active
    input wire logic prog_valid_out // Commit strobe
);
    logic [16:0] busy_n_q;
    logic [5:0] pulse_n_q;
    always_ff @(posedge sys_clk_in) begin
        busy_n_q <= busy_out ? busy_n_q + 17'h1 : 17'h0;
    end
    always_ff @(posedge sys_clk_in) begin
        pulse_n_q <= busy_out ? pulse_n_q + {5'h0, prog_valid_out} : 6'h0;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    dev_oe_stable_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
        else $error("device data moved with clock high");
    ack_scl_low_a: assert property ($rose(sda_dev_oe) |-> !scl ##1 !scl)
        else $error("acknowledge not raised in clock low");
    ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
        else $error("acknowledge dropped early");
    ack_length_a: assert property ($rose(sda_dev_oe) |-> ##[95:105] $fell(sda_dev_oe))
        else $error("acknowledge not one bit long");
    busy_silent_a: assert property (busy_out |-> !sda_dev_oe)
        else $error("device answered while programming");
    busy_after_stop_a: assert property ($rose(busy_out) |-> scl && sda && !$past(sda, 12))
        else $error("programming began without stop");
    busy_length_a: assert property ($fell(busy_out) |->
        busy_n_q >= PROG_CYCLES - 2 && busy_n_q <= PROG_CYCLES + 2)
        else $error("programming time wrong");
    commit_in_busy_a: assert property (prog_valid_out |-> busy_out)
        else $error("commit outside programming");
    commit_count_a: assert property (prog_valid_out |-> pulse_n_q < 6'h20)
        else $error("more than one page committed");
    cover property ($rose(busy_out));
    cover property ($rose(sda_dev_oe));
    cover property (pulse_n_q == 6'h20);
endmodule
`default_nettype wire

// >>> verif/serial_eeprom_bus_slave_write_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_slave_write_bench;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wp = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [2:0] cmd_strap = 3'h0;
    logic [15:0] cmd_addr = 16'h0;
    logic [5:0] cmd_len = 6'h0;
    logic [7:0] base = 8'h0;
    logic [7:0] idx = 8'h0;
    logic [7:0] pg;
    logic [7:0] n_commit = 8'h0;
    logic [7:0] cm [0:31];
    logic cmd_ready, take, done, nack, pv, busy;
    logic [12:0] pa;
    logic [7:0] pd;
    wire logic [7:0] data = base + idx;
    int fails = 0;
    int n_tests = 0;
    seeb_link_if link ();
    seeb_dev #(.PROG_CYCLES(2000)) i_seeb_dev (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .link(link), .strap_select_bit0_in(strap[0]), .strap_select_bit1_in(strap[1]),
        .strap_select_bit2_in(strap[2]), .write_protect_in(wp), .prog_valid_out(pv),
        .prog_addr_out(pa), .prog_data_out(pd), .busy_out(busy));
    seeb_host i_seeb_host (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link),
        .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_strap_in(cmd_strap),
        .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len), .data_in(data), .data_take_out(take),
        .done_out(done), .nack_out(nack));
    seeb_link_sva #(.PROG_CYCLES(2000)) i_seeb_link_sva (.sys_clk_in(sys_clk_in),
        .reset_in(reset_in), .scl(link.scl), .sda(link.sda), .sda_dev_oe(link.sda_dev_oe),
        .busy_out(busy), .prog_valid_out(pv));
    initial forever #50 sys_clk_in = ~sys_clk_in;
    // Next data byte after each take; commits gathered per command
    always @(posedge sys_clk_in) begin
        if (take === 1'b1) idx <= idx + 8'h1;
        if (cmd_valid && cmd_ready) n_commit <= 8'h0;
        else if (pv === 1'b1) begin
            n_commit <= n_commit + 8'h1;
            cm[pa[4:0]] <= pd;
            pg <= pa[12:5];
        end
    end
    task stop_test;
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task run(input logic [2:0] st, input logic [15:0] a, input logic [5:0] n,
             input logic [7:0] b);
        int i;
        @(posedge sys_clk_in);
        cmd_valid <= 1'b1;
        cmd_strap <= st;
        cmd_addr <= a;
        cmd_len <= n;
        base <= b - idx;
        @(posedge sys_clk_in);
        cmd_valid <= 1'b0;
        for (i = 0; i < 40000 && done !== 1'b1; i++) wait_cyc(1);
        if (i == 40000) begin
            fails++;
            stop_test;
        end
    endtask
    task wait_idle;
        int i;
        for (i = 0; i < 3000 && busy !== 1'b0; i++) wait_cyc(1);
        if (i == 3000) begin
            fails++;
            stop_test;
        end
    endtask
    task s_byte;
        run(3'h0, 16'he123, 6'h1, 8'h3c);
        chk("nack", 8'h0, {7'h0, nack});
        wait_cyc(45);
        chk("commits", 8'h1, n_commit);
        chk("page", 8'h09, pg);
        chk("data", 8'h3c, cm[3]);
        chk("busy", 8'h1, {7'h0, busy});
        run(3'h0, 16'h0, 6'h0, 8'h0);
        chk("poll busy", 8'h1, {7'h0, nack});
        wait_idle;
        run(3'h0, 16'h0, 6'h0, 8'h0);
        chk("poll idle", 8'h0, {7'h0, nack});
    endtask
    task s_mismatch;
        run(3'h2, 16'h0100, 6'h1, 8'h77);
        chk("nack", 8'h1, {7'h0, nack});
        wait_cyc(45);
        chk("commits", 8'h0, n_commit);
    endtask
    task s_page;
        run(3'h5, 16'h1f3e, 6'h20, 8'h40);
        chk("nack", 8'h0, {7'h0, nack});
        wait_cyc(45);
        chk("commits", 8'h20, n_commit);
        chk("page", 8'hf9, pg);
        for (int k = 0; k < 32; k++) chk("byte", 8'h40 + 8'(k), cm[5'(k + 30)]);
        wait_idle;
    endtask
    task s_protect;
        @(posedge sys_clk_in);
        wp <= 1'b1;
        run(3'h5, 16'h0200, 6'h2, 8'h11);
        chk("nack", 8'h0, {7'h0, nack});
        wait_cyc(45);
        chk("busy", 8'h0, {7'h0, busy});
        chk("commits", 8'h0, n_commit);
        @(posedge sys_clk_in);
        wp <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        s_byte;
        @(posedge sys_clk_in);
        strap <= 3'h5;
        s_mismatch;
        s_page;
        s_protect;
        stop_test;
    end
endmodule
`default_nettype wire
